// *** logic/limit_pkg.sv ***
// constants, field layout and register map of the limit test and binning controller
// assumes a single 20 MHz clock and an APB master with 32-bit data
package limit_pkg;
   localparam int DATA_W = 32;
   localparam int NUM_LIM = 10;
   localparam int PAT_W = 4;
   localparam int LOC_W = 7;
   localparam int ADDR_W = 8;
   localparam int ENTRY_W = 2 * DATA_W + 3 * PAT_W;
   // entry layout inside the limit table
   localparam int LO_LSB = 0;
   localparam int HI_LSB = DATA_W;
   localparam int PLO_LSB = 2 * DATA_W;
   localparam int PHI_LSB = PLO_LSB + PAT_W;
   localparam int PPASS_LSB = PHI_LSB + PAT_W;
   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
   localparam logic [ADDR_W-1:0] LIM_EN_OFF = 8'h04;
   localparam logic [ADDR_W-1:0] CMD_OFF = 8'h08;
   localparam logic [ADDR_W-1:0] RESULT_OFF = 8'h0c;
   localparam logic [ADDR_W-1:0] PATS_OFF = 8'h10;
   localparam logic [ADDR_W-1:0] NEXT_OFF = 8'h14;
   localparam logic [ADDR_W-1:0] PORT_OFF = 8'h18;
   localparam logic [ADDR_W-1:0] DELAY_OFF = 8'h1c;
   localparam logic [ADDR_W-1:0] LIM_BASE = 8'h40;
   localparam int LIM_STRIDE = 16;
   // control register fields
   localparam int C_FEED = 0;
   localparam int C_COMP_IN = 2;
   localparam int C_COMP_EN = 3;
   localparam int C_SORT = 4;
   localparam int C_IMM = 5;
   localparam int C_AUTOCLR = 6;
   localparam int C_WIDTH4 = 7;
   localparam int C_BUSY = 8;
   localparam int C_POL_LOW = 9;
   localparam int CTRL_W = 10;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   // command bits
   localparam int CMD_CLEAR = 0;
   localparam int CMD_PORT_CLEAR = 1;
   // pattern register fields
   localparam int P_COMP = 0;
   localparam int P_PASS = 4;
   localparam int P_FAIL = 8;
   localparam int P_CLEAR = 12;
   // next-step register fields
   localparam int N_PASS_LOC = 0;
   localparam int N_PASS_NEXT = 7;
   localparam int N_FAIL_LOC = 8;
   localparam int N_FAIL_NEXT = 15;
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int CYC_PER_US = CLK_HZ / 1_000_000;
   localparam int EOT_PULSE_US = 10;
   localparam int EOT_PULSE_CYC = (EOT_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int MAX_DELAY_S = 60;
   localparam int MAX_DELAY_US = MAX_DELAY_S * 1_000_000;
   localparam int DELAY_W = 26;

   typedef enum logic [1:0] {FEED_CALC, FEED_VOLT, FEED_CURR, FEED_RES} feed_t;

   function automatic logic lim_hit(input logic [ADDR_W-1:0] a);
      lim_hit = (a >= LIM_BASE) && (a < ADDR_W'(LIM_BASE + LIM_STRIDE * NUM_LIM))
                && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
   endfunction : lim_hit

   function automatic logic [3:0] lim_idx(input logic [ADDR_W-1:0] a);
      lim_idx = 4'((a - LIM_BASE) >> 4);
   endfunction : lim_idx
endpackage : limit_pkg

// *** logic/limit_mem_if.sv ***
// carrier between controller and its limit table
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface limit_mem_if #(parameter int W = 76, parameter int D = 10);
   logic wr_en;
   logic [$clog2(D)-1:0] wr_addr;
   logic [W-1:0] wr_data;
   logic [W-1:0] wr_mask;
   logic [$clog2(D)-1:0] bus_addr;
   logic [W-1:0] bus_rdata;
   logic [$clog2(D)-1:0] scan_addr;
   logic [W-1:0] scan_rdata;
   modport ctl (output wr_en, wr_addr, wr_data, wr_mask, bus_addr, scan_addr, input bus_rdata, scan_rdata);
   modport mem (input wr_en, wr_addr, wr_data, wr_mask, bus_addr, scan_addr, output bus_rdata, scan_rdata);
endinterface : limit_mem_if
`default_nettype wire

// *** logic/limit_table.sv ***
// bound and pattern storage, one masked write port, two registered read ports
// assumes write mask selects the field being updated
`timescale 1ns/1ns
`default_nettype none
module limit_table #(parameter int W = 76, parameter int D = 10) (
   input wire logic clk,
   input wire logic ce,
   limit_mem_if.mem m
);
   logic [W-1:0] mem_q [D];

   always_ff @(posedge clk) begin
      if (ce && m.wr_en) begin
         mem_q[m.wr_addr] <= (mem_q[m.wr_addr] & ~m.wr_mask) | (m.wr_data & m.wr_mask);
      end
   end

   always_ff @(posedge clk) begin
      if (ce) begin
         m.bus_rdata <= mem_q[m.bus_addr];
         m.scan_rdata <= mem_q[m.scan_addr];
      end
   end
endmodule : limit_table
`default_nettype wire

// *** logic/band_compare.sv ***
// signed band check of one reading against one bound pair
// assumes both bounds already in the reading's format
`timescale 1ns/1ns
`default_nettype none
module band_compare #(parameter int W = 32) (
   input wire logic signed [W-1:0] value,
   input wire logic signed [W-1:0] lower,
   input wire logic signed [W-1:0] upper,
   output logic below,
   output logic above
);
   // equal to a bound counts as inside
   assign below = value < lower;
   assign above = value > upper;
endmodule : band_compare
`default_nettype wire

// *** logic/limit_binning_ctrl.sv ***
// limit test and binning controller with APB register access
// assumes readings and compliance flag come from logic on clk
`timescale 1ns/1ns
`default_nettype none
module limit_binning_ctrl #(
   parameter int unsigned AUTOCLR_MAX_US = limit_pkg::MAX_DELAY_US
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [limit_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [limit_pkg::DATA_W-1:0] calc_value,
   input wire logic signed [limit_pkg::DATA_W-1:0] volt_value,
   input wire logic signed [limit_pkg::DATA_W-1:0] curr_value,
   input wire logic signed [limit_pkg::DATA_W-1:0] res_value,
   input wire logic reading_valid,
   input wire logic reading_last,
   input wire logic in_compliance,
   output logic [limit_pkg::PAT_W-1:0] port_lines,
   output logic [limit_pkg::LOC_W-1:0] next_sweep_point,
   output logic next_point_is_next,
   output logic next_point_valid
);
   import limit_pkg::*;

   typedef enum {ST_IDLE, ST_SCAN, ST_DECIDE} eval_state_t;

   limit_mem_if #(.W(ENTRY_W), .D(NUM_LIM)) mif ();

   limit_table #(.W(ENTRY_W), .D(NUM_LIM)) u_table (
      .clk(clk),
      .ce(ce),
      .m(mif.mem)
   );

   logic [CTRL_W-1:0] ctrl_q;
   logic [NUM_LIM-1:0] lim_en_q;
   logic [NUM_LIM:0] result_q;
   logic [15:0] pats_q;
   logic [15:0] next_q;
   logic [PAT_W-1:0] port_q;
   logic [DELAY_W-1:0] delay_q;
   logic ack_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;
   logic hit;
   logic wr_acc;
   logic clear_cmd;
   logic port_clear_cmd;
   eval_state_t state_q;
   logic [3:0] idx_q;
   logic [3:0] chk_idx_q;
   logic chk_vld_q;
   logic signed [DATA_W-1:0] val_q;
   logic last_q;
   logic rd_fail_q;
   logic [PAT_W-1:0] rd_pat_q;
   logic band_q;
   logic comp_q;
   logic [PAT_W-1:0] band_pat_q;
   logic sw_fail_q;
   logic [PAT_W-1:0] sw_pat_q;
   logic sweep_q;
   logic dec_fail;
   logic [PAT_W-1:0] dec_pat;
   logic acc_fail;
   logic [PAT_W-1:0] acc_pat;
   logic [PAT_W-1:0] out_pat;
   logic emit;
   logic out_fail;
   logic comp_fail;
   logic below;
   logic above;
   logic [30:0] ac_cnt_q;
   logic ac_run_q;
   logic ac_expire;
   logic [7:0] eot_cnt_q;
   logic busy;
   logic line4;
   logic [ENTRY_W-1:0] wmask;
   logic [ENTRY_W-1:0] wdata;

   wire logic sorting = ctrl_q[C_SORT];
   wire logic imm = ctrl_q[C_IMM];
   wire logic [PAT_W-1:0] clear_pat = pats_q[P_CLEAR +: PAT_W];

   // apb: one wait cycle on every access so table reads have settled
   assign pready = psel && penable && ack_q;
   assign hit = lim_hit(paddr) || (paddr == CTRL_OFF) || (paddr == LIM_EN_OFF) || (paddr == CMD_OFF)
                || (paddr == RESULT_OFF) || (paddr == PATS_OFF) || (paddr == NEXT_OFF)
                || (paddr == PORT_OFF) || (paddr == DELAY_OFF);
   assign pslverr = pready && !hit;
   assign prdata = prdata_q;
   assign wr_acc = ce && pready && pwrite && hit;
   assign clear_cmd = wr_acc && (paddr == CMD_OFF) && pwdata[CMD_CLEAR];
   assign port_clear_cmd = wr_acc && (paddr == CMD_OFF) && pwdata[CMD_PORT_CLEAR];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_q <= 1'b0;
      end else if (ce) begin
         ack_q <= psel && penable && !ack_q;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (lim_hit(paddr)) begin
         unique case (paddr[3:2])
            2'h0: rd_mux = mif.bus_rdata[LO_LSB +: DATA_W];
            2'h1: rd_mux = mif.bus_rdata[HI_LSB +: DATA_W];
            default: rd_mux = {20'h00000, mif.bus_rdata[PLO_LSB +: 3 * PAT_W]};
         endcase
      end else if (paddr == CTRL_OFF) begin
         rd_mux = {22'h000000, ctrl_q};
      end else if (paddr == LIM_EN_OFF) begin
         rd_mux = {22'h000000, lim_en_q};
      end else if (paddr == RESULT_OFF) begin
         rd_mux = {21'h000000, result_q};
      end else if (paddr == PATS_OFF) begin
         rd_mux = {16'h0000, pats_q};
      end else if (paddr == NEXT_OFF) begin
         rd_mux = {16'h0000, next_q};
      end else if (paddr == PORT_OFF) begin
         rd_mux = {28'h0000000, port_lines};
      end else if (paddr == DELAY_OFF) begin
         rd_mux = {6'h00, delay_q};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata_q <= 32'h0000_0000;
      end else if (ce && psel && penable && !ack_q) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
   end

   // software-written configuration
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RST;
         lim_en_q <= '0;
         pats_q <= 16'h0000;
         next_q <= 16'h0000;
         delay_q <= '0;
      end else if (wr_acc) begin
         if (paddr == CTRL_OFF) begin
            ctrl_q <= pwdata[CTRL_W-1:0];
         end
         if (paddr == LIM_EN_OFF) begin
            lim_en_q <= pwdata[NUM_LIM-1:0];
         end
         if (paddr == PATS_OFF) begin
            pats_q <= pwdata[15:0];
         end
         if (paddr == NEXT_OFF) begin
            next_q <= pwdata[15:0];
         end
         if (paddr == DELAY_OFF) begin
            delay_q <= (pwdata > AUTOCLR_MAX_US) ? DELAY_W'(AUTOCLR_MAX_US) : pwdata[DELAY_W-1:0];
         end
      end
   end

   // table write: bounds and per-limit patterns
   always_comb begin
      wmask = '0;
      wdata = '0;
      unique case (paddr[3:2])
         2'h0: begin
            wmask[LO_LSB +: DATA_W] = '1;
            wdata[LO_LSB +: DATA_W] = pwdata;
         end
         2'h1: begin
            wmask[HI_LSB +: DATA_W] = '1;
            wdata[HI_LSB +: DATA_W] = pwdata;
         end
         default: begin
            wmask[PLO_LSB +: 3 * PAT_W] = '1;
            wdata[PLO_LSB +: 3 * PAT_W] = pwdata[3 * PAT_W-1:0];
         end
      endcase
   end

   assign mif.wr_en = wr_acc && lim_hit(paddr);
   assign mif.wr_addr = lim_idx(paddr);
   assign mif.wr_data = wdata;
   assign mif.wr_mask = wmask;
   assign mif.bus_addr = lim_idx(paddr);
   assign mif.scan_addr = (idx_q < 4'(NUM_LIM)) ? idx_q : 4'h0;

   band_compare #(.W(DATA_W)) u_cmp (
      .value(val_q),
      .lower(mif.scan_rdata[LO_LSB +: DATA_W]),
      .upper(mif.scan_rdata[HI_LSB +: DATA_W]),
      .below(below),
      .above(above)
   );

   assign comp_fail = ctrl_q[C_COMP_EN] && (ctrl_q[C_COMP_IN] ? in_compliance : !in_compliance);

   // evaluation sequence: latch, scan table, decide
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         idx_q <= 4'h0;
         chk_idx_q <= 4'h0;
         chk_vld_q <= 1'b0;
         val_q <= '0;
         last_q <= 1'b0;
      end else if (ce) begin
         unique case (state_q)
            ST_IDLE: begin
               if (reading_valid) begin
                  unique case (feed_t'(ctrl_q[C_FEED +: 2]))
                     FEED_CALC: val_q <= calc_value;
                     FEED_VOLT: val_q <= volt_value;
                     FEED_CURR: val_q <= curr_value;
                     FEED_RES: val_q <= res_value;
                  endcase
                  last_q <= reading_last;
                  idx_q <= 4'h0;
                  state_q <= ST_SCAN;
               end
            end
            ST_SCAN: begin
               chk_idx_q <= idx_q;
               if (idx_q == 4'(NUM_LIM)) begin
                  chk_vld_q <= 1'b0;
                  state_q <= ST_DECIDE;
               end else begin
                  chk_vld_q <= 1'b1;
                  idx_q <= idx_q + 4'h1;
               end
            end
            ST_DECIDE: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // per-reading accumulation of first failure and first passing band
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_fail_q <= 1'b0;
         rd_pat_q <= '0;
         band_q <= 1'b0;
         band_pat_q <= '0;
         comp_q <= 1'b0;
      end else if (ce) begin
         if (state_q == ST_IDLE && reading_valid) begin
            rd_fail_q <= comp_fail;
            comp_q <= comp_fail;
            rd_pat_q <= pats_q[P_COMP +: PAT_W];
            band_q <= 1'b0;
         end else if (chk_vld_q && lim_en_q[chk_idx_q]) begin
            if ((below || above) && !rd_fail_q) begin
               rd_fail_q <= 1'b1;
               rd_pat_q <= above ? mif.scan_rdata[PHI_LSB +: PAT_W] : mif.scan_rdata[PLO_LSB +: PAT_W];
            end
            if (!below && !above && !band_q) begin
               band_q <= 1'b1;
               band_pat_q <= mif.scan_rdata[PPASS_LSB +: PAT_W];
            end
         end
      end
   end

   // result flags: a new result wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         result_q <= '0;
      end else if (ce) begin
         if (clear_cmd) begin
            result_q <= '0;
         end
         if (state_q == ST_IDLE && reading_valid && ctrl_q[C_COMP_EN]) begin
            result_q[0] <= comp_fail;
         end
         if (chk_vld_q && lim_en_q[chk_idx_q]) begin
            result_q[chk_idx_q + 4'h1] <= below || above;
         end
      end
   end

   // decision of one reading
   always_comb begin
      if (!sorting) begin
         dec_fail = rd_fail_q;
         dec_pat = rd_fail_q ? rd_pat_q : pats_q[P_PASS +: PAT_W];
      end else if (comp_q) begin
         dec_fail = 1'b1;
         dec_pat = pats_q[P_COMP +: PAT_W];
      end else if (lim_en_q == '0) begin
         dec_fail = 1'b0;
         dec_pat = pats_q[P_PASS +: PAT_W];
      end else if (band_q) begin
         dec_fail = 1'b0;
         dec_pat = band_pat_q;
      end else begin
         dec_fail = 1'b1;
         dec_pat = pats_q[P_FAIL +: PAT_W];
      end
   end

   // in sorting a compliance failure may still have found a band; the compliance result rules
   assign acc_fail = sw_fail_q || dec_fail;
   assign acc_pat = sw_fail_q ? sw_pat_q : dec_pat;
   assign emit = (state_q == ST_DECIDE) && (imm || sorting || last_q);
   assign out_pat = (sorting || imm) ? dec_pat : acc_pat;
   assign out_fail = (sorting || imm) ? dec_fail : acc_fail;

   // sweep accumulation for end-of-sweep update
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sw_fail_q <= 1'b0;
         sw_pat_q <= '0;
         sweep_q <= 1'b0;
      end else if (ce) begin
         if (emit) begin
            sw_fail_q <= 1'b0;
            sweep_q <= 1'b0;
         end else if (state_q == ST_DECIDE) begin
            sweep_q <= 1'b1;
            if (dec_fail && !sw_fail_q) begin
               sw_fail_q <= 1'b1;
               sw_pat_q <= dec_pat;
            end
         end else if (clear_cmd) begin
            sw_fail_q <= 1'b0;
            sweep_q <= 1'b0;
         end
      end
   end

   // next sweep point
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         next_sweep_point <= '0;
         next_point_is_next <= 1'b0;
         next_point_valid <= 1'b0;
      end else if (ce) begin
         next_point_valid <= emit;
         if (emit) begin
            next_sweep_point <= out_fail ? next_q[N_FAIL_LOC +: LOC_W] : next_q[N_PASS_LOC +: LOC_W];
            next_point_is_next <= out_fail ? next_q[N_FAIL_NEXT] : next_q[N_PASS_NEXT];
         end
      end
   end

   // auto-clear timer
   assign ac_expire = ac_run_q && (ac_cnt_q == 31'h0);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ac_cnt_q <= 31'h0;
         ac_run_q <= 1'b0;
      end else if (ce) begin
         if (emit && ctrl_q[C_AUTOCLR]) begin
            ac_cnt_q <= 31'(delay_q * 31'(CYC_PER_US));
            ac_run_q <= 1'b1;
         end else if (ac_expire || clear_cmd || port_clear_cmd) begin
            ac_run_q <= 1'b0;
         end else if (ac_run_q) begin
            ac_cnt_q <= ac_cnt_q - 31'h1;
         end
      end
   end

   // port pattern: later assignments take priority
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_q <= '0;
      end else if (ce) begin
         if (ac_expire) begin
            port_q <= clear_pat;
         end
         if (clear_cmd || port_clear_cmd) begin
            port_q <= clear_pat;
         end
         if (wr_acc && paddr == PORT_OFF) begin
            port_q <= pwdata[PAT_W-1:0];
         end
         if (emit) begin
            port_q <= out_pat;
         end
      end
   end

   // end-of-test pulse length
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eot_cnt_q <= 8'h00;
      end else if (ce) begin
         if (emit) begin
            eot_cnt_q <= 8'(EOT_PULSE_CYC);
         end else if (eot_cnt_q != 8'h00) begin
            eot_cnt_q <= eot_cnt_q - 8'h01;
         end
      end
   end

   assign busy = (state_q != ST_IDLE) || sweep_q;

   always_comb begin
      if (ctrl_q[C_BUSY]) begin
         line4 = busy ^ ctrl_q[C_POL_LOW];
      end else if (ctrl_q[C_WIDTH4]) begin
         line4 = port_q[PAT_W-1];
      end else begin
         line4 = (eot_cnt_q != 8'h00) ^ ctrl_q[C_POL_LOW];
      end
   end

   // bit 0 drives line 1
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_lines <= '0;
      end else if (ce) begin
         port_lines <= {line4, port_q[PAT_W-2:0]};
      end
   end
endmodule : limit_binning_ctrl
`default_nettype wire

// *** tb/limit_binning_properties.sv ***
// port checker for the binning controller
// assumes ce held high
`timescale 1ns/1ns
`default_nettype none
module limit_binning_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [limit_pkg::ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic reading_valid,
   input wire logic next_point_valid
);
   import limit_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("bad wait state");
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready too long");
   a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("stray error");
   a_map_ok: assert property (pready && paddr <= DELAY_OFF && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped refused");
   a_gap_err: assert property (pready && paddr >= LIM_BASE && paddr < 8'he0 && paddr[3:0] == 4'hc |-> pslverr)
      else $error("gap accepted");
   a_cmd_zero: assert property (pready && !pwrite && paddr == CMD_OFF |-> prdata == 32'h0)
      else $error("command read");
   a_eval_time: assert property (next_point_valid |-> $past(reading_valid, 13))
      else $error("late result");
   a_point_pulse: assert property (next_point_valid |=> !next_point_valid)
      else $error("long point pulse");
endmodule : limit_binning_properties
bind limit_binning_ctrl limit_binning_properties props (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .reading_valid(reading_valid), .next_point_valid(next_point_valid));
`default_nettype wire

// *** tb/handler_model.sv ***
// parts handler: bins on each rising line 4
// assumes active-high strobe
`timescale 1ns/1ns
`default_nettype none
module handler_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] lines,
   output logic [2:0] bin
);
   logic l4_q;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         l4_q <= 1'b0;
         bin <= 3'h0;
      end else begin
         l4_q <= lines[3];
         if (lines[3] && !l4_q) bin <= lines[2:0];
      end
   end
endmodule : handler_model
`default_nettype wire

// *** tb/limit_binning_ctrl_tb.sv ***
// bench: apb accesses and readings
// assumes checker bound to the controller
`timescale 1ns/1ns
`default_nettype none
module limit_binning_ctrl_tb;
   import limit_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rv = 1'b0, inc = 1'b1;
   logic rlast = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic signed [31:0] v = 32'sh0;
   logic pready, pslverr, nxt, nxt_valid, e;
   logic [3:0] lines;
   logic [6:0] loc;
   logic [2:0] bin;
   int bad_count = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   limit_binning_ctrl uut (.clk(clk), .rstn(rstn), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .calc_value(-v),
      .volt_value(v), .curr_value(~v), .res_value(-v), .reading_valid(rv), .reading_last(rlast),
      .in_compliance(inc), .port_lines(lines), .next_sweep_point(loc), .next_point_is_next(nxt),
      .next_point_valid(nxt_valid));
   handler_model hm (.clk(clk), .rstn(rstn), .lines(lines), .bin(bin));
   task automatic end_sim;
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rr,
      output logic ee);
      int i;
      logic rdy;
      i = 0;
      rdy = 1'b0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // answer taken from settled values just ahead of the accepting edge
      do begin
         @(negedge clk);
         rdy = pready;
         rr = prdata;
         ee = pslverr;
         @(posedge clk);
         i++;
      end while (rdy !== 1'b1 && i < 20);
      if (rdy !== 1'b1) begin
         bad_count++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask : rd
   task automatic port(input logic [3:0] x);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(32'(lines), 32'(x));
      @(posedge clk);
   endtask : port
   // result lands on the port lines 13 edges after acceptance
   task automatic meas(input int mv, input logic [3:0] x);
      v <= mv;
      rv <= 1'b1;
      @(posedge clk);
      rv <= 1'b0;
      repeat (17) @(posedge clk);
      port(x);
   endtask : meas
   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      port(4'h0);
      rd(CTRL_OFF, 32'h0);
      wr(LIM_BASE, 32'd750);
      wr(LIM_BASE + 8'h04, 32'd850);
      wr(LIM_BASE + 8'h08, 32'h522);
      wr(LIM_BASE + 8'h10, 32'd780);
      wr(LIM_BASE + 8'h14, 32'd820);
      wr(LIM_BASE + 8'h18, 32'h433);
      wr(PATS_OFF, 32'ha91c);
      wr(NEXT_OFF, 32'h8005);
      wr(LIM_EN_OFF, 32'h3);
      wr(CTRL_OFF, 32'ha1);
      meas(800, 4'h1);
      rd(RESULT_OFF, 32'h0);
      meas(760, 4'h3);
      meas(850, 4'h3);
      meas(900, 4'h2);
      rd(RESULT_OFF, 32'h6);
      wr(CTRL_OFF, 32'h81);
      rlast <= 1'b0;
      meas(760, 4'h2);
      rlast <= 1'b1;
      meas(800, 4'h3);
      wr(CTRL_OFF, 32'hb1);
      meas(800, 4'h5);
      chk(32'({nxt, loc}), 32'h05);
      meas(900, 4'h9);
      chk(32'(nxt), 32'h1);
      wr(LIM_EN_OFF, 32'h0);
      wr(CTRL_OFF, 32'hb9);
      meas(900, 4'h1);
      inc <= 1'b0;
      meas(900, 4'hc);
      wr(CTRL_OFF, 32'hbd);
      meas(900, 4'h1);
      rd(RESULT_OFF, 32'h6);
      wr(CMD_OFF, 32'h1);
      port(4'ha);
      rd(RESULT_OFF, 32'h0);
      rd(CMD_OFF, 32'h0);
      wr(PORT_OFF, 32'h6);
      port(4'h6);
      rd(PORT_OFF, 32'h6);
      wr(CMD_OFF, 32'h2);
      port(4'ha);
      rd(LIM_BASE + 8'h18, 32'h433);
      wr(LIM_EN_OFF, 32'h3);
      wr(CTRL_OFF, 32'h31);
      wr(PORT_OFF, 32'hf);
      // let the end-of-test pulse of the last reading run out
      repeat (200) @(posedge clk);
      port(4'h7);
      wr(DELAY_OFF, 32'h2);
      wr(CTRL_OFF, 32'h71);
      meas(800, 4'hd);
      chk(32'(bin), 32'h5);
      repeat (40) @(posedge clk);
      port(4'ha);
      repeat (200) @(posedge clk);
      port(4'h2);
      wr(CTRL_OFF, 32'h231);
      port(4'ha);
      apb(1'b0, 8'h4c, 32'h0, r, e);
      chk(32'(e), 32'h1);
      wr(CTRL_OFF, 32'h301);
      rlast <= 1'b0;
      meas(760, 4'h2);
      end_sim();
   end
endmodule : limit_binning_ctrl_tb
`default_nettype wire
